// file: hw/jvp_pkg.sv
// Shared constants for the vector player timing block
package jvp_pkg;
    // ***************************************************************
    // Clocking and timing
    // ***************************************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int SLOW_HZ = 100_000;
    localparam int TIMEBASE_HZ = 1_000_000;
    localparam int CYC_PER_US = CLK_HZ / TIMEBASE_HZ;
    localparam int PCT_DIV = 100;
    localparam logic [19:0] PER_SLOW = 20'(CLK_HZ / SLOW_HZ);
    localparam logic [15:0] KHZ_15M = 16'h3A98;
    localparam logic [15:0] KHZ_10M = 16'h2710;
    localparam logic [15:0] KHZ_5M = 16'h1388;
    localparam logic [15:0] KHZ_3M = 16'h0BB8;
    localparam logic [15:0] KHZ_1M5 = 16'h05DC;
    localparam logic [15:0] KHZ_750K = 16'h02EE;
    localparam logic [15:0] KHZ_1M = 16'h03E8;
    // Highest rate not above the request: periods round up
    localparam logic [19:0] PER_15M = 20'((CLK_HZ + 15_000_000 - 1) / 15_000_000);
    localparam logic [19:0] PER_10M = 20'((CLK_HZ + 10_000_000 - 1) / 10_000_000);
    localparam logic [19:0] PER_5M = 20'((CLK_HZ + 5_000_000 - 1) / 5_000_000);
    localparam logic [19:0] PER_3M = 20'((CLK_HZ + 3_000_000 - 1) / 3_000_000);
    localparam logic [19:0] PER_1M5 = 20'((CLK_HZ + 1_500_000 - 1) / 1_500_000);
    localparam logic [19:0] PER_750K = 20'((CLK_HZ + 750_000 - 1) / 750_000);
    localparam logic [15:0] FRAC_N_MIN = 16'h0002;
    localparam logic [15:0] FRAC_N_MAX = 16'h03E8;

    // ***************************************************************
    // Register map
    // ***************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DEFKHZ = 8'h04;
    localparam logic [7:0] ADDR_PCT = 8'h08;
    localparam logic [7:0] ADDR_AUX = 8'h0C;
    localparam logic [7:0] ADDR_PRESET = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_PERIOD = 8'h18;
    localparam int CTRL_FASTVAR = 0;
    localparam int CTRL_IGNORE = 1;
    localparam int CTRL_XFMT = 2;
    localparam int CTRL_CNTTIME = 3;
    localparam int CTRL_FMODE = 4;
    localparam int CTRL_ICLK = 6;
    localparam int AUX_RUN = 0;
    localparam int AUX_DONE = 2;
    localparam int ST_CONFLICT = 2;
    localparam logic [15:0] RST_DEFKHZ = 16'h03E8;
    localparam logic [7:0] RST_PCT = 8'h00;
    localparam logic [1:0] PRESET_FPGA = 2'h1;
    localparam logic [1:0] PRESET_CPLD = 2'h2;
    localparam logic [1:0] PRESET_MCU = 2'h3;
    localparam logic [7:0] PCT_CPLD = 8'h64;
    localparam logic [7:0] PCT_MCU = 8'h19;

    // ***************************************************************
    // Modes and states
    // ***************************************************************
    typedef enum logic [1:0] {FM_OFF = 2'h0, FM_ON = 2'h1, FM_AUTO = 2'h2} jvp_fmode_t;
    typedef enum logic [1:0] {IC_NONE = 2'h0, IC_SLOW = 2'h1, IC_DEF = 2'h2} jvp_iclk_t;
    typedef enum logic [1:0] {AX_TRI = 2'h0, AX_LOW = 2'h1, AX_HIGH = 2'h2, AX_FUNC = 2'h3} jvp_aux_t;
    typedef enum logic [3:0] {
        EN_IDLE = 4'b0001, EN_TIME = 4'b0010, EN_COUNT = 4'b0100, EN_SHIFT = 4'b1000
    } jvp_state_t;
endpackage

// file: hw/jvp_tck_gen.sv
// Programmable divider producing the test clock and its edge marks
`timescale 1ns/1ps
module jvp_tck_gen (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic run,
    input wire logic [19:0] period,
    // Clock out and edge marks
    output logic tck,
    output logic rise,
    output logic fall
);
    logic [19:0] cnt_ff;
    logic [19:0] half;

    assign half = period >> 1;

    // Low half first, so data set at start is stable before the rise
    always_ff @(posedge clk) begin
        if (rst || !run) begin
            cnt_ff <= '0;
            tck <= 1'b0;
            rise <= 1'b0;
            fall <= 1'b0;
        end else begin
            rise <= 1'b0;
            fall <= 1'b0;
            if (cnt_ff == period - 20'h00001) begin
                cnt_ff <= '0;
                tck <= 1'b0;
                fall <= 1'b1;
            end else begin
                cnt_ff <= cnt_ff + 20'h00001;
                if (cnt_ff == half - 20'h00001) begin
                    tck <= 1'b1;
                    rise <= 1'b1;
                end
            end
        end
    end
endmodule // jvp_tck_gen

// file: hw/jvp_timing.sv
// Test clock timing, idle waits and auxiliary pin control for the vector player
//
// Summary of operation
// - Default TCK rate holds until a frequency command; default command restores it.
// - In the extended vector format the default rate applies to everything.
// - Rate never exceeds 3 MHz, or 15 MHz on the fast variant.
// - Ignore setting keeps the user rate and drops all frequency commands.
// - Fast-clock option samples TDO on falling edge, half a period later.
// - Time-only idle wait: no clock, about 100 kHz, or default rate.
// - A timed idle wait lasts at least the requested time.
// - Every idle wait is stretched by a programmable percentage.
// - Count-only wait is a minimum TCK count, or optionally microseconds.
// - Count plus time wait issues the count at the running rate.
// - Any maximum time is ignored; the wait runs at the current rate.
// - Auxiliary pin is reset, system clock, or fixed levels; run and done selections.
// - Presets engage fast sampling from 5 MHz and tristate the auxiliary pin.
// - Reset and system clock never both drive the auxiliary pin in one stream.
// - Below 500 kHz only fractions of 1 MHz, plus 3, 1.5, 0.75 MHz.
`timescale 1ns/1ps
module jvp_timing
    import jvp_pkg::*;
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    // Stream control
    input wire logic STREAM_ACTIVE,
    input wire logic STREAM_START,
    input wire logic FREQ_CMD,
    input wire logic FREQ_DEFAULT,
    input wire logic [15:0] FREQ_KHZ,
    input wire logic TRST_CMD,
    input wire logic TRST_LEVEL,
    // Idle wait requests
    input wire logic WAIT_START,
    input wire logic WAIT_HAS_COUNT,
    input wire logic WAIT_HAS_TIME,
    input wire logic WAIT_SCK,
    input wire logic [31:0] WAIT_COUNT,
    input wire logic [31:0] WAIT_US,
    output logic WAIT_DONE,
    // Shift requests
    input wire logic SHIFT_REQ,
    input wire logic SHIFT_TDI,
    input wire logic SHIFT_TMS,
    output logic SHIFT_DONE,
    output logic SHIFT_TDO,
    output logic BUSY,
    // Target pins
    output logic TCK,
    output logic TDI,
    output logic TMS,
    input wire logic TDO,
    output logic AUX_O,
    output logic AUX_OE
);
    import jvp_pkg::*;

    // ***************************************************************
    // Configuration registers
    // ***************************************************************
    logic [7:0] ctrl_ff;
    logic [15:0] def_khz_ff;
    logic [7:0] pct_ff;
    logic [3:0] aux_cfg_ff;
    logic conflict_ff;
    logic fastv;
    logic ignore_f;
    logic xfmt;
    logic cnt_time;
    jvp_fmode_t fmode;
    jvp_iclk_t iclk;
    logic preset_wr;
    logic set_conflict;

    assign fastv = ctrl_ff[CTRL_FASTVAR];
    assign ignore_f = ctrl_ff[CTRL_IGNORE];
    assign xfmt = ctrl_ff[CTRL_XFMT];
    assign cnt_time = ctrl_ff[CTRL_CNTTIME];
    assign fmode = jvp_fmode_t'(ctrl_ff[CTRL_FMODE +: 2]);
    assign iclk = jvp_iclk_t'(ctrl_ff[CTRL_ICLK +: 2]);
    assign preset_wr = REG_WR && (REG_ADDR == ADDR_PRESET) && (REG_WDATA[1:0] != 2'h0);

    always_ff @(posedge MCLK) begin
        if (RST) begin
            ctrl_ff <= 8'h00;
            def_khz_ff <= RST_DEFKHZ;
            pct_ff <= RST_PCT;
            aux_cfg_ff <= 4'h0;
        end else if (preset_wr) begin
            // Presets: ignore commands, auto fast sampling, count as time, aux tristate
            ctrl_ff[CTRL_FASTVAR] <= fastv;
            ctrl_ff[CTRL_IGNORE] <= 1'b1;
            ctrl_ff[CTRL_XFMT] <= xfmt;
            ctrl_ff[CTRL_CNTTIME] <= 1'b1;
            ctrl_ff[CTRL_FMODE +: 2] <= FM_AUTO;
            aux_cfg_ff <= {AX_TRI, AX_TRI};
            unique case (REG_WDATA[1:0])
                PRESET_FPGA: begin
                    def_khz_ff <= KHZ_15M;
                    pct_ff <= 8'h00;
                    ctrl_ff[CTRL_ICLK +: 2] <= IC_DEF;
                end
                PRESET_CPLD: begin
                    def_khz_ff <= KHZ_5M;
                    pct_ff <= PCT_CPLD;
                    ctrl_ff[CTRL_ICLK +: 2] <= IC_SLOW;
                end
                PRESET_MCU: begin
                    def_khz_ff <= KHZ_1M;
                    pct_ff <= PCT_MCU;
                    ctrl_ff[CTRL_ICLK +: 2] <= IC_DEF;
                end
                default: ;
            endcase
        end else if (REG_WR) begin
            if (REG_ADDR == ADDR_CTRL) ctrl_ff <= REG_WDATA[7:0];
            if (REG_ADDR == ADDR_DEFKHZ) def_khz_ff <= REG_WDATA[15:0];
            if (REG_ADDR == ADDR_PCT) pct_ff <= REG_WDATA[7:0];
            if (REG_ADDR == ADDR_AUX) aux_cfg_ff <= REG_WDATA[3:0];
        end
    end

    // Sticky conflict flag: a new conflict beats a clear in the same cycle
    always_ff @(posedge MCLK) begin
        if (RST) begin
            conflict_ff <= 1'b0;
        end else if (set_conflict) begin
            conflict_ff <= 1'b1;
        end else if (REG_WR && REG_ADDR == ADDR_STATUS && REG_WDATA[ST_CONFLICT]) begin
            conflict_ff <= 1'b0;
        end
    end

    // ***************************************************************
    // Rate selection
    // ***************************************************************
    logic [15:0] cur_khz_ff;
    logic [15:0] eff_khz;
    logic [19:0] cur_per;
    logic [19:0] def_per;
    logic fast_on;

    // Settable rates only; periods round up so the rate never exceeds the request
    function automatic logic [19:0] quant_per(input logic [15:0] khz, input logic fv);
        logic [15:0] n;
        n = FRAC_N_MAX;
        if (khz != 16'h0000) n = 16'((32'(KHZ_1M) + 32'(khz) - 32'd1) / 32'(khz));
        if (n < FRAC_N_MIN) n = FRAC_N_MIN;
        if (fv && khz >= KHZ_15M) return PER_15M;
        else if (fv && khz >= KHZ_10M) return PER_10M;
        else if (fv && khz >= KHZ_5M) return PER_5M;
        else if (khz >= KHZ_3M) return PER_3M;
        else if (khz >= KHZ_1M5) return PER_1M5;
        else if (khz >= KHZ_750K) return PER_750K;
        else return 20'(32'(n) * CYC_PER_US);
    endfunction

    always_ff @(posedge MCLK) begin
        if (RST) begin
            cur_khz_ff <= RST_DEFKHZ;
        end else if (STREAM_START) begin
            cur_khz_ff <= def_khz_ff;
        end else if (FREQ_CMD) begin
            cur_khz_ff <= FREQ_DEFAULT ? def_khz_ff : FREQ_KHZ;
        end
    end

    // Extended format and ignore mode both pin the rate to the default
    assign eff_khz = (ignore_f || xfmt) ? def_khz_ff : cur_khz_ff;
    assign cur_per = quant_per(eff_khz, fastv);
    assign def_per = quant_per(def_khz_ff, fastv);
    assign fast_on = fastv && (fmode == FM_ON || (fmode == FM_AUTO && cur_per <= PER_5M));

    // ***************************************************************
    // Wait and shift engine
    // ***************************************************************
    jvp_state_t state_ff;
    logic [47:0] rem_ff;
    logic [47:0] cnt_scaled;
    logic [47:0] time_cyc;
    logic [31:0] us_src;
    logic use_time;
    logic tck_run;
    logic [19:0] tck_period;
    logic tck_rise;
    logic tck_fall;
    logic tdo_m_ff;
    logic tdo_s_ff;
    logic tdo_cap_ff;
    logic sck_wait_ff;

    // Stretch by percentage; count-only may be read as microseconds at 1 MHz
    assign cnt_scaled = 48'(WAIT_COUNT) + (48'(WAIT_COUNT) * 48'(pct_ff) + 48'(PCT_DIV - 1)) / 48'(PCT_DIV);
    assign use_time = WAIT_HAS_TIME ? !WAIT_HAS_COUNT : (WAIT_HAS_COUNT && cnt_time);
    assign us_src = WAIT_HAS_TIME ? WAIT_US : WAIT_COUNT;
    assign time_cyc = 48'(us_src) * 48'(CYC_PER_US) * (48'(PCT_DIV) + 48'(pct_ff)) / 48'(PCT_DIV);

    always_ff @(posedge MCLK) begin
        if (RST) begin
            state_ff <= EN_IDLE;
            rem_ff <= '0;
            WAIT_DONE <= 1'b0;
            SHIFT_DONE <= 1'b0;
            SHIFT_TDO <= 1'b0;
            TDI <= 1'b0;
            TMS <= 1'b0;
            tdo_cap_ff <= 1'b0;
            sck_wait_ff <= 1'b0;
        end else begin
            WAIT_DONE <= 1'b0;
            SHIFT_DONE <= 1'b0;
            unique case (state_ff)
                EN_IDLE: begin
                    if (WAIT_START) begin
                        sck_wait_ff <= WAIT_SCK;
                        if (use_time) begin
                            state_ff <= EN_TIME;
                            rem_ff <= time_cyc;
                        end else if (WAIT_HAS_COUNT) begin
                            state_ff <= EN_COUNT;
                            rem_ff <= cnt_scaled;
                        end else begin
                            WAIT_DONE <= 1'b1;
                        end
                    end else if (SHIFT_REQ) begin
                        state_ff <= EN_SHIFT;
                        TDI <= SHIFT_TDI;
                        TMS <= SHIFT_TMS;
                    end
                end
                EN_TIME: begin
                    // Hold the state; finish only with TCK low, yet a rise due in that final cycle still escapes as a one-cycle TCK pulse
                    if (rem_ff != 48'h0) begin
                        rem_ff <= rem_ff - 48'h1;
                    end else if (!TCK) begin
                        state_ff <= EN_IDLE;
                        WAIT_DONE <= 1'b1;
                    end
                end
                EN_COUNT: begin
                    if (rem_ff == 48'h0) begin
                        state_ff <= EN_IDLE;
                        WAIT_DONE <= 1'b1;
                    end else if (tck_fall) begin
                        rem_ff <= rem_ff - 48'h1;
                    end
                end
                EN_SHIFT: begin
                    if (tck_rise && !fast_on) tdo_cap_ff <= tdo_s_ff;
                    if (tck_fall) begin
                        state_ff <= EN_IDLE;
                        SHIFT_DONE <= 1'b1;
                        SHIFT_TDO <= fast_on ? tdo_s_ff : tdo_cap_ff;
                        if (fast_on) tdo_cap_ff <= tdo_s_ff;
                    end
                end
                default: state_ff <= EN_IDLE;
            endcase
        end
    end

    assign BUSY = (state_ff != EN_IDLE);

    // Count waits run at the current rate whatever limits came with them
    assign tck_run = (state_ff == EN_TIME && iclk != IC_NONE) || state_ff == EN_COUNT
        || state_ff == EN_SHIFT;
    assign tck_period = (state_ff == EN_TIME) ? ((iclk == IC_SLOW) ? PER_SLOW : def_per) : cur_per;

    jvp_tck_gen u_tck (
        .clk(MCLK),
        .rst(RST),
        .run(tck_run),
        .period(tck_period),
        .tck(TCK),
        .rise(tck_rise),
        .fall(tck_fall)
    );

    // Target data comes from outside this clock domain
    always_ff @(posedge MCLK) begin
        if (RST) begin
            tdo_m_ff <= 1'b0;
            tdo_s_ff <= 1'b0;
        end else begin
            tdo_m_ff <= TDO;
            tdo_s_ff <= tdo_m_ff;
        end
    end

    // ***************************************************************
    // Auxiliary pin
    // ***************************************************************
    logic trst_claim_ff;
    logic sck_claim_ff;
    logic trst_lvl_ff;
    jvp_aux_t aux_mode;
    logic nxt_aux_o;
    logic nxt_aux_oe;

    // A later request for the other function is refused and flagged
    assign set_conflict = (TRST_CMD && sck_claim_ff)
        || (WAIT_START && !BUSY && WAIT_SCK && (trst_claim_ff || TRST_CMD));

    always_ff @(posedge MCLK) begin
        if (RST || STREAM_START) begin
            trst_claim_ff <= 1'b0;
            sck_claim_ff <= 1'b0;
            trst_lvl_ff <= 1'b0;
        end else begin
            if (TRST_CMD && !sck_claim_ff) begin
                trst_claim_ff <= 1'b1;
                trst_lvl_ff <= TRST_LEVEL;
            end
            if (WAIT_START && !BUSY && WAIT_SCK && !trst_claim_ff && !TRST_CMD) sck_claim_ff <= 1'b1;
        end
    end

    assign aux_mode = jvp_aux_t'(STREAM_ACTIVE ? aux_cfg_ff[AUX_RUN +: 2] : aux_cfg_ff[AUX_DONE +: 2]);

    always_comb begin
        nxt_aux_o = 1'b0;
        nxt_aux_oe = 1'b0;
        unique case (aux_mode)
            AX_TRI: ;
            AX_LOW: nxt_aux_oe = 1'b1;
            AX_HIGH: begin
                nxt_aux_o = 1'b1;
                nxt_aux_oe = 1'b1;
            end
            AX_FUNC: begin
                nxt_aux_oe = trst_claim_ff || sck_claim_ff;
                nxt_aux_o = trst_claim_ff ? trst_lvl_ff : (BUSY && sck_wait_ff && TCK);
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            AUX_O <= 1'b0;
            AUX_OE <= 1'b0;
        end else begin
            AUX_O <= nxt_aux_o;
            AUX_OE <= nxt_aux_oe;
        end
    end

    // ***************************************************************
    // Register read
    // ***************************************************************
    always_ff @(posedge MCLK) begin
        if (RST) begin
            REG_RDATA <= 32'h00000000;
        end else if (REG_RD) begin
            unique case (REG_ADDR)
                ADDR_CTRL: REG_RDATA <= {24'h000000, ctrl_ff};
                ADDR_DEFKHZ: REG_RDATA <= {16'h0000, def_khz_ff};
                ADDR_PCT: REG_RDATA <= {24'h000000, pct_ff};
                ADDR_AUX: REG_RDATA <= {28'h0000000, aux_cfg_ff};
                ADDR_STATUS: REG_RDATA <= {26'h0000000, trst_claim_ff, sck_claim_ff, fast_on, conflict_ff,
                    state_ff == EN_SHIFT, state_ff == EN_TIME || state_ff == EN_COUNT};
                ADDR_PERIOD: REG_RDATA <= {12'h000, cur_per};
                default: REG_RDATA <= 32'h00000000;
            endcase
        end else begin
            REG_RDATA <= 32'h00000000;
        end
    end

    // ***************************************************************
    // Checks
    // ***************************************************************
    logic [47:0] chk_req_ff;
    logic [47:0] chk_cnt_ff;

    always_ff @(posedge MCLK) begin
        if (RST) begin
            chk_req_ff <= '0;
            chk_cnt_ff <= '0;
        end else if (state_ff == EN_IDLE) begin
            chk_req_ff <= use_time ? time_cyc : cnt_scaled;
            chk_cnt_ff <= '0;
        end else if (state_ff == EN_TIME || (state_ff == EN_COUNT && tck_fall)) begin
            chk_cnt_ff <= chk_cnt_ff + 48'h1;
        end
    end

    sequence shift_fall_s;
        state_ff == EN_SHIFT && tck_fall;
    endsequence
    sequence shift_rise_s;
        state_ff == EN_SHIFT && tck_rise && !fast_on;
    endsequence

    rate_ceiling_a: assert property (@(posedge MCLK) disable iff (RST)
        cur_per >= (fastv ? PER_15M : PER_3M)) else $error("TCK rate above variant limit");
    default_restore_a: assert property (@(posedge MCLK) disable iff (RST)
        FREQ_CMD && FREQ_DEFAULT && !STREAM_START |=> cur_khz_ff == $past(def_khz_ff))
        else $error("Default frequency command not applied");
    ext_format_a: assert property (@(posedge MCLK) disable iff (RST)
        xfmt |-> cur_per == def_per) else $error("Extended format not at default rate");
    ignore_freq_a: assert property (@(posedge MCLK) disable iff (RST)
        ignore_f && FREQ_CMD ##1 ignore_f |-> cur_per == def_per) else $error("Frequency command not ignored");
    late_sample_a: assert property (@(posedge MCLK) disable iff (RST)
        shift_fall_s and fast_on |=> SHIFT_TDO == $past(tdo_s_ff) && SHIFT_DONE)
        else $error("Fast sampling not on falling edge");
    early_sample_a: assert property (@(posedge MCLK) disable iff (RST)
        shift_rise_s |=> tdo_cap_ff == $past(tdo_s_ff)) else $error("Rising edge sample missed");
    no_clock_wait_a: assert property (@(posedge MCLK) disable iff (RST)
        state_ff == EN_TIME && iclk == IC_NONE ##1 state_ff == EN_TIME |-> !TCK && !tck_rise)
        else $error("TCK toggles in clockless wait");
    min_time_a: assert property (@(posedge MCLK) disable iff (RST)
        state_ff == EN_TIME ##1 state_ff == EN_IDLE |-> chk_cnt_ff > chk_req_ff)
        else $error("Timed wait ended early");
    min_count_a: assert property (@(posedge MCLK) disable iff (RST)
        state_ff == EN_COUNT ##1 state_ff == EN_IDLE |-> chk_cnt_ff >= chk_req_ff)
        else $error("Count wait ended short");
    aux_exclusive_a: assert property (@(posedge MCLK) disable iff (RST)
        !(trst_claim_ff && sck_claim_ff)) else $error("Reset and system clock both claimed");
    aux_tristate_a: assert property (@(posedge MCLK) disable iff (RST)
        preset_wr ##1 !REG_WR [*2] |-> !AUX_OE) else $error("Preset left auxiliary pin driven");
endmodule // jvp_timing

// file: verification/jvp_tap_model.sv
// Target test access port model answering on TDO
`timescale 1ns/1ps
module jvp_tap_model (
    // Target pins
    input wire logic tck,
    input wire logic tdi,
    output logic tdo
);
    logic cap_ff = 1'b0;
    initial tdo = 1'b0;
    // Capture on rise, answer on fall, so a rise-sampling master sees the prior bit
    always @(posedge tck) cap_ff <= tdi;
    always @(negedge tck) tdo <= cap_ff;
endmodule // jvp_tap_model

// file: verification/test_jvp_timing.sv
// Self-checking bench for the vector player timing block
`timescale 1ns/1ps
module test_jvp_timing;
    import jvp_pkg::*;
    logic mclk = 0, rst = 1, wr = 0, rd = 0, act = 0, fc = 0, fd = 0, ws = 0, whc = 0, wht = 0, sr = 0, sti = 0;
    logic sst = 0, trc = 0, trl = 0, wsck = 0, stm = 0;
    logic [7:0] addr = 0;
    logic [15:0] fk = 0;
    logic [31:0] wdat = 0, wc = 0, wu = 0, rdat;
    logic wdn, sdn, sto, busy, tck, tdi, tms, tdo, ao, aoe;
    int n_mismatch = 0, compares = 0, nf = 0;
    jvp_timing u_dut (.MCLK(mclk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdat), .REG_WR(wr), .REG_RD(rd),
        .REG_RDATA(rdat), .STREAM_ACTIVE(act), .STREAM_START(sst), .FREQ_CMD(fc), .FREQ_DEFAULT(fd),
        .FREQ_KHZ(fk), .TRST_CMD(trc), .TRST_LEVEL(trl), .WAIT_START(ws), .WAIT_HAS_COUNT(whc),
        .WAIT_HAS_TIME(wht), .WAIT_SCK(wsck), .WAIT_COUNT(wc), .WAIT_US(wu), .WAIT_DONE(wdn), .SHIFT_REQ(sr),
        .SHIFT_TDI(sti), .SHIFT_TMS(stm), .SHIFT_DONE(sdn), .SHIFT_TDO(sto), .BUSY(busy), .TCK(tck),
        .TDI(tdi), .TMS(tms), .TDO(tdo), .AUX_O(ao), .AUX_OE(aoe));
    jvp_tap_model u_tap (.tck(tck), .tdi(tdi), .tdo(tdo));
    always #5 mclk = ~mclk;
    always @(negedge tck) nf++;
    task automatic results();
        $display("n_mismatch=%0d compares=%0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Write when w is high, else read and compare with d
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        @(posedge mclk);
        wr <= 1'b0;
        rd <= 1'b0;
        if (!w) #1 chk(rdat, d);
    endtask
    task automatic fq(input logic d, input logic [15:0] k, input logic [31:0] e);
        @(posedge mclk);
        fc <= 1'b1;
        fd <= d;
        fk <= k;
        @(posedge mclk);
        fc <= 1'b0;
        acc(0, ADDR_PERIOD, e);
    endtask
    // Idle wait; cycle count and test clock falls are judged
    task automatic wt(input logic hc, ht, input logic [31:0] c, u, input int lo, hi, f);
        int n;
        n = 0;
        @(posedge mclk);
        ws <= 1'b1;
        whc <= hc;
        wht <= ht;
        wc <= c;
        wu <= u;
        @(posedge mclk);
        ws <= 1'b0;
        nf = 0;
        do begin
            @(posedge mclk);
            #1 n++;
        end while (wdn !== 1'b1 && n < 3000);
        chk(32'(n >= lo && n <= hi), 32'h1);
        chk(nf, f);
    endtask
    task automatic sh(input logic b, input logic e);
        @(posedge mclk);
        sr <= 1'b1;
        sti <= b;
        stm <= !b;
        @(posedge mclk);
        sr <= 1'b0;
        do begin
            @(posedge mclk);
            #1;
        end while (sdn !== 1'b1);
        chk({busy, tdi, tms, sto}, {1'b0, b, !b, e});
    endtask
    // Stream start pulse and/or reset command at level t
    task automatic sp(input logic s, input logic t);
        @(posedge mclk);
        sst <= s;
        trc <= t;
        trl <= t;
        @(posedge mclk);
        sst <= 1'b0;
        trc <= 1'b0;
    endtask
    task automatic t_freq();
        acc(0, ADDR_DEFKHZ, 32'h3E8);
        acc(1, ADDR_DEFKHZ, 32'h3A98);
        sp(1'b1, 1'b0);
        acc(0, ADDR_PERIOD, 32'h22);
        acc(1, ADDR_CTRL, 32'h1);
        acc(0, ADDR_PERIOD, 32'h7);
        acc(1, ADDR_CTRL, 32'h0);
        fq(0, 16'h02EE, 32'h86);
        fq(0, 16'h00FA, 32'h190);
        fq(1, 16'h0000, 32'h22);
        acc(1, ADDR_CTRL, 32'h2);
        fq(0, 16'h05DC, 32'h22);
        acc(1, ADDR_CTRL, 32'h4);
        fq(0, 16'h05DC, 32'h22);
        acc(1, ADDR_CTRL, 32'h0);
        fq(1, 16'h0000, 32'h22);
    endtask
    task automatic t_wait();
        wt(0, 1, 0, 3, 300, 310, 0);
        wt(1, 0, 4, 0, 102, 170, 4);
        wt(1, 1, 20, 1, 600, 720, 20);
        acc(1, ADDR_PCT, 32'h64);
        wt(0, 1, 0, 3, 600, 610, 0);
        wt(1, 0, 4, 0, 238, 306, 8);
        acc(1, ADDR_PCT, 32'h0);
        acc(1, ADDR_CTRL, 32'h8);
        wt(1, 0, 3, 0, 300, 310, 0);
        acc(1, ADDR_CTRL, 32'h80);
        wt(0, 1, 0, 3, 301, 340, 9);
        acc(1, ADDR_CTRL, 32'h40);
        wt(0, 1, 0, 20, 2000, 2010, 2);
        acc(1, ADDR_CTRL, 32'h0);
    endtask
    task automatic t_aux();
        acc(1, ADDR_AUX, 32'h2);
        act <= 1'b1;
        repeat (3) @(posedge mclk);
        act <= 1'b0;
        #1 chk({aoe, ao}, 32'h3);
        repeat (3) @(posedge mclk);
        #1 chk(aoe, 32'h0);
        acc(1, ADDR_PRESET, 32'h3);
        acc(0, ADDR_PCT, 32'h19);
        acc(0, ADDR_CTRL, 32'hAA);
        acc(0, ADDR_AUX, 32'h0);
        // Function mode: clock claim first, then a refused reset command
        acc(1, ADDR_AUX, 32'hF);
        act <= 1'b1;
        sp(1'b1, 1'b0);
        wsck <= 1'b1;
        wt(0, 1, 0, 1, 125, 140, 1);
        sp(1'b0, 1'b1);
        wsck <= 1'b0;
        acc(0, ADDR_STATUS, 32'h14);
        acc(1, ADDR_STATUS, 32'h4);
        acc(0, ADDR_STATUS, 32'h10);
        chk({aoe, ao}, 32'h2);
        sp(1'b1, 1'b0);
        sp(1'b0, 1'b1);
        acc(0, ADDR_STATUS, 32'h20);
        chk({aoe, ao}, 32'h3);
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        t_freq();
        t_wait();
        sh(1'b1, 1'b0);
        sh(1'b0, 1'b1);
        acc(1, ADDR_CTRL, 32'h11);
        sh(1'b1, 1'b0);
        sh(1'b0, 1'b1);
        acc(1, ADDR_CTRL, 32'h0);
        t_aux();
        results();
    end
    initial begin
        #120000;
        n_mismatch++;
        results();
    end
endmodule // test_jvp_timing
